// >>> svcp_pkg.sv
// Purpose: Constants and types for the volatile chip settings command block.
// Assumes: Command and response reports are 64 bytes, one byte per handshake.
// Notes:   Each number used by the design lives here once.
`default_nettype none
package svcp_pkg;
	// ----------------------------------------------------------------
	// Report layout
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_SET_VOLATILE = 8'h21;
	localparam logic [7:0] STATUS_OK        = 8'h00;
	localparam logic [7:0] FILL_BYTE        = 8'h00;
	localparam logic [5:0] IDX_FIRST        = 6'h00;
	localparam logic [5:0] IDX_STATUS       = 6'h01;
	localparam logic [5:0] IDX_PIN0         = 6'h04;
	localparam logic [5:0] IDX_OUT          = 6'h0D;
	localparam logic [5:0] IDX_DIR          = 6'h0F;
	localparam logic [5:0] IDX_DIR_HI       = 6'h10;
	localparam logic [5:0] IDX_OTHER        = 6'h11;
	localparam logic [5:0] IDX_LAST         = 6'h3F;
	localparam int         STAGE_BYTES      = 14;
	localparam int         PIN_COUNT        = 9;
	localparam int         WAKE_BIT         = 4;
	localparam int         MODE_LSB         = 1;
	localparam int         SPI_BIT          = 0;
	// ----------------------------------------------------------------
	// Pin functions and counting modes
	// ----------------------------------------------------------------
	localparam logic [7:0] FUNC_CODE_GPIO   = 8'h00;
	localparam logic [7:0] FUNC_CODE_CS     = 8'h01;
	localparam logic [7:0] FUNC_CODE_DED    = 8'h02;
	localparam logic [2:0] MODE_NONE        = 3'h0;
	localparam logic [2:0] MODE_HIGH_PULSES = 3'h4;
	// ----------------------------------------------------------------
	// Reset values of the volatile settings
	// ----------------------------------------------------------------
	localparam logic [1:0]  RST_FUNC        = 2'h0;
	localparam logic [7:0]  RST_OUT         = 8'h00;
	localparam logic [15:0] RST_DIR         = 16'hFFFF;
	localparam logic        RST_WAKE        = 1'b0;
	localparam logic        RST_SPI_HOLD    = 1'b0;

	typedef logic [1:0] svcp_func_t;
	typedef logic [STAGE_BYTES-1:0][7:0] svcp_stage_t;
	typedef enum logic [1:0] {
		ST_RECV  = 2'b00,
		ST_APPLY = 2'b01,
		ST_RESP  = 2'b11
	} svcp_state_t;
endpackage : svcp_pkg
`default_nettype wire

// >>> svcp_pin_if.sv
// Purpose: Carrier between the command decoder and one pin function holder.
// Assumes: One instance per general pin.
// Notes:   Load is a one-cycle strobe.
`default_nettype none
interface svcp_pin_if;
	logic [7:0]          code;
	logic                load;
	svcp_pkg::svcp_func_t func;
	modport host (output code, output load, input func);
	modport pin  (input code, input load, output func);
endinterface : svcp_pin_if
`default_nettype wire

// >>> svcp_pin_decode.sv
// Purpose: Holds the volatile function of one general pin.
// Assumes: Code is stable while load is high.
// Notes:   Input-only pins accept no chip select function.
`default_nettype none
module svcp_pin_decode #(
	parameter bit INPUT_ONLY = 1'b0
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	svcp_pin_if.pin   pif
);
	import svcp_pkg::*;

	logic code_ok;
	logic [1:0] func_reg;

	// [RQ3] Listed encodings.
	assign code_ok = (pif.code == FUNC_CODE_GPIO) || (pif.code == FUNC_CODE_DED)
		|| ((pif.code == FUNC_CODE_CS) && !INPUT_ONLY);

	// [RQ12] Invalid code ignored.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			func_reg <= RST_FUNC;
		end else if (pif.load && code_ok) begin
			func_reg <= pif.code[1:0];
		end
	end
	assign pif.func = func_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_func_load;
		pif.load && code_ok |=> func_reg == $past(pif.code[1:0]);
	endproperty
	a_func_load: assert property (p_func_load) else $error("pin function not loaded"); // [RQ3]

	property p_func_reject;
		pif.load && !code_ok |=> $stable(func_reg);
	endproperty
	a_func_reject: assert property (p_func_reject) else $error("invalid code applied"); // [RQ12]
endmodule : svcp_pin_decode
`default_nettype wire

// >>> svcp_settings_cmd.sv
// Purpose: Decodes the volatile chip settings command and sends its response.
// Assumes: Report bytes arrive in index order with a valid/ready handshake.
// Notes:   Reports with another command code are consumed without answer.
// Operation
// [RQ1] Byte zero 0x21 marks a settings update and routes the report to this handler.
// [RQ2] The host fills bytes 1 to 3 and 18 to 63 with zero; the device ignores them.
// [RQ3] Bytes 4 to 12 set the functions of pins 0 to 8, pin 8 allowing only input or dedicated.
// [RQ4] Byte 13 gives the default output levels of pins 7 to 0 and byte 14 is ignored.
// [RQ5] Byte 15 gives the default directions of pins 7 to 0 and byte 16 is the upper half.
// [RQ6] Bit 4 of byte 17 enables remote wake-up when one and disables it when zero.
// [RQ7] Bits 3 to 1 of byte 17 select the interrupt counting mode, codes above 4 reserved.
// [RQ8] Bit 0 of byte 17 at one keeps the SPI bus held between transfers, at zero releases it.
// [RQ9] The 64-byte response echoes 0x21 in byte zero.
// [RQ10] Response byte 1 carries 0x00 for successful completion.
// [RQ11] Decoded fields go only to the volatile settings and take effect on acceptance.
// [RQ12] An unlisted pin code or a reserved counting mode is not applied.
`default_nettype none
module svcp_settings_cmd (
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	input  wire logic                 cmd_valid,
	input  wire logic [7:0]           cmd_data,
	output logic                      cmd_ready,
	output logic                      rsp_valid,
	output logic [7:0]                rsp_data,
	output logic                      rsp_last,
	input  wire logic                 rsp_ready,
	output logic                      settings_applied,
	output svcp_pkg::svcp_func_t      pin_func [svcp_pkg::PIN_COUNT],
	output logic [7:0]                default_out,
	output logic [15:0]               default_dir,
	output logic                      wake_en,
	output logic [2:0]                int_mode,
	output logic                      spi_hold
);
	import svcp_pkg::*;

	// ----------------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------------
	svcp_state_t state_reg;
	logic [5:0]  cmd_idx_reg;
	logic [7:0]  cmd_code_reg;
	svcp_stage_t stage_reg;
	logic [5:0]  stage_sel;
	logic        cmd_take;
	logic        rsp_take;
	logic [5:0]  rsp_idx_reg;
	logic [7:0]  rsp_data_reg;
	logic [2:0]  mode_code;
	logic        apply;

	assign cmd_ready = (state_reg == ST_RECV);
	assign cmd_take  = cmd_valid && cmd_ready;
	assign rsp_valid = (state_reg == ST_RESP);
	assign rsp_take  = rsp_valid && rsp_ready;
	assign rsp_last  = rsp_valid && (rsp_idx_reg == IDX_LAST);
	assign apply     = (state_reg == ST_APPLY);
	assign stage_sel = cmd_idx_reg - IDX_PIN0;
	assign mode_code = stage_reg[IDX_OTHER-IDX_PIN0][MODE_LSB +: 3];
	assign settings_applied = apply;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_idx_reg <= IDX_FIRST;
		end else if (cmd_take) begin
			cmd_idx_reg <= cmd_idx_reg + 6'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_code_reg <= FILL_BYTE;
		end else if (cmd_take && cmd_idx_reg == IDX_FIRST) begin
			cmd_code_reg <= cmd_data;
		end
	end

	// [RQ2] Reserved bytes not staged.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stage_reg <= '0;
		end else if (cmd_take && cmd_idx_reg >= IDX_PIN0 && cmd_idx_reg <= IDX_OTHER) begin
			stage_reg[stage_sel[3:0]] <= cmd_data;
		end
	end

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	// [RQ1] Route on command code.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_RECV;
		end else begin
			case (state_reg)
				ST_RECV: begin
					if (cmd_take && cmd_idx_reg == IDX_LAST
						&& cmd_code_reg == CMD_SET_VOLATILE) begin
						state_reg <= ST_APPLY;
					end
				end
				ST_APPLY: begin
					state_reg <= ST_RESP;
				end
				ST_RESP: begin
					if (rsp_take && rsp_idx_reg == IDX_LAST) begin
						state_reg <= ST_RECV;
					end
				end
				default: begin
					state_reg <= ST_RECV;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin functions
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			svcp_pin_if u_if ();
			// [RQ11] Load on acceptance.
			assign u_if.code = stage_reg[gi];
			assign u_if.load = apply;
			assign pin_func[gi] = u_if.func;
			svcp_pin_decode #(
				.INPUT_ONLY (gi == PIN_COUNT - 1)
			) u_pin (
				.ref_clk (ref_clk),
				.nrst    (nrst),
				.pif     (u_if.pin)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Volatile settings
	// ----------------------------------------------------------------
	// [RQ4] Output levels low byte.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			default_out <= RST_OUT;
		end else if (apply) begin
			default_out <= stage_reg[IDX_OUT-IDX_PIN0];
		end
	end

	// [RQ5] Direction word.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			default_dir <= RST_DIR;
		end else if (apply) begin
			default_dir <= {stage_reg[IDX_DIR_HI-IDX_PIN0], stage_reg[IDX_DIR-IDX_PIN0]};
		end
	end

	// [RQ6] Remote wake-up enable.
	// [RQ8] SPI bus hold option.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wake_en  <= RST_WAKE;
			spi_hold <= RST_SPI_HOLD;
		end else if (apply) begin
			wake_en  <= stage_reg[IDX_OTHER-IDX_PIN0][WAKE_BIT];
			spi_hold <= stage_reg[IDX_OTHER-IDX_PIN0][SPI_BIT];
		end
	end

	// [RQ7] Counting mode, reserved kept out.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			int_mode <= MODE_NONE;
		end else if (apply && mode_code <= MODE_HIGH_PULSES) begin
			int_mode <= mode_code;
		end
	end

	// ----------------------------------------------------------------
	// Response
	// ----------------------------------------------------------------
	// [RQ9] Echo code first.
	// [RQ10] Success status next.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rsp_idx_reg  <= IDX_FIRST;
			rsp_data_reg <= FILL_BYTE;
		end else if (apply) begin
			rsp_idx_reg  <= IDX_FIRST;
			rsp_data_reg <= CMD_SET_VOLATILE;
		end else if (rsp_take) begin
			rsp_idx_reg  <= rsp_idx_reg + 6'h01;
			rsp_data_reg <= (rsp_idx_reg == IDX_FIRST) ? STATUS_OK : FILL_BYTE;
		end
	end
	assign rsp_data = rsp_data_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_apply;
		state_reg == ST_APPLY;
	endsequence
	sequence s_resp_open;
		s_apply ##1 rsp_valid;
	endsequence

	property p_route;
		s_apply |-> cmd_code_reg == CMD_SET_VOLATILE && cmd_idx_reg == IDX_FIRST;
	endproperty
	a_route: assert property (p_route) else $error("apply without matching code"); // [RQ1]

	property p_echo;
		s_resp_open |-> rsp_data == CMD_SET_VOLATILE && rsp_idx_reg == IDX_FIRST;
	endproperty
	a_echo: assert property (p_echo) else $error("response does not echo code"); // [RQ9]

	property p_status;
		rsp_valid && rsp_idx_reg == IDX_STATUS |-> rsp_data == STATUS_OK;
	endproperty
	a_status: assert property (p_status) else $error("status byte not success"); // [RQ10]

	property p_out;
		s_apply |=> default_out == $past(stage_reg[IDX_OUT-IDX_PIN0]);
	endproperty
	a_out: assert property (p_out) else $error("output levels not applied"); // [RQ4]

	property p_dir;
		s_apply |=> default_dir[7:0] == $past(stage_reg[IDX_DIR-IDX_PIN0]);
	endproperty
	a_dir: assert property (p_dir) else $error("directions not applied"); // [RQ5]

	property p_wake;
		s_apply |=> wake_en == $past(stage_reg[IDX_OTHER-IDX_PIN0][WAKE_BIT]);
	endproperty
	a_wake: assert property (p_wake) else $error("wake-up enable wrong"); // [RQ6]

	property p_spi;
		s_apply |=> spi_hold == $past(stage_reg[IDX_OTHER-IDX_PIN0][SPI_BIT]);
	endproperty
	a_spi: assert property (p_spi) else $error("bus hold option wrong"); // [RQ8]

	property p_mode;
		s_apply |=> (int_mode <= MODE_HIGH_PULSES) && ($past(mode_code) > MODE_HIGH_PULSES
			? $stable(int_mode) : int_mode == $past(mode_code));
	endproperty
	a_mode: assert property (p_mode) else $error("counting mode handled wrongly"); // [RQ7]

	property p_hold;
		!apply |=> $stable(default_out) && $stable(default_dir) && $stable(wake_en);
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed without command"); // [RQ11]
endmodule : svcp_settings_cmd
`default_nettype wire

// >>> svcp_host_model.sv
// Purpose: Host model that sends 64-byte command reports and takes responses.
// Assumes: Requests change at the falling edge and hold until taken.
// Notes:   With slow set the host takes one response byte in four.
`default_nettype none
module svcp_host_model (
	input  wire logic       ref_clk,
	input  wire logic       slow,
	output var  logic       cmd_valid,
	output var  logic [7:0] cmd_data,
	input  wire logic       cmd_ready,
	output var  logic       rsp_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] stall_cnt = 2'h0;
	initial begin
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
		rsp_ready = 1'b0;
	end
	// Response side, prompt or stalling.
	always @(negedge ref_clk) begin
		stall_cnt <= stall_cnt + 2'h1;
		rsp_ready <= !slow || (stall_cnt == 2'h2);
	end
	task automatic send_report(input logic [63:0][7:0] rep);
		logic ready_seen;
		int   w;
		for (int i = 0; i < 64; i++) begin
			@(negedge ref_clk);
			cmd_valid = 1'b1;
			cmd_data = ((i >= 1 && i <= 3) || i >= 18) ? 8'h00 : rep[i];
			ready_seen = cmd_ready;
			w = 0;
			while (!ready_seen && w < 400) begin
				@(negedge ref_clk);
				ready_seen = cmd_ready;
				w++;
			end
			@(posedge ref_clk);
		end
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd_data = ~cmd_data;
	endtask : send_report
endmodule : svcp_host_model
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the volatile chip settings command block.
// Assumes: Results are seen just before the edge that takes them.
// Notes:   Expected settings and response bytes wait in queues.
`default_nettype none
module tb;
	import svcp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        slow = 1'b0;
	logic        cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready, settings_applied;
	logic [7:0]  cmd_data, rsp_data, default_out;
	logic [15:0] default_dir;
	logic        wake_en, spi_hold, pend;
	logic [2:0]  int_mode;
	svcp_func_t  pin_func [PIN_COUNT];
	integer      seed = 32'h4c83f598;
	integer      n_errors = 0;
	integer      comparisons = 0;
	logic [8:0]  rsp_q [$];
	logic [46:0] set_q [$];
	logic [46:0] rst_set = {{9{RST_FUNC}}, RST_OUT, RST_DIR, RST_WAKE, MODE_NONE, RST_SPI_HOLD};
	logic [46:0] e_set;
	always #5 ref_clk = ~ref_clk;
	svcp_settings_cmd svcp_settings_cmd_i (.ref_clk(ref_clk), .nrst(nrst),
		.cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
		.rsp_ready(rsp_ready), .settings_applied(settings_applied), .pin_func(pin_func),
		.default_out(default_out), .default_dir(default_dir), .wake_en(wake_en),
		.int_mode(int_mode), .spi_hold(spi_hold));
	svcp_host_model svcp_host_model_i (.ref_clk(ref_clk), .slow(slow), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_ready(rsp_ready));
	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [46:0] seen_set();
		logic [46:0] v;
		v = {18'h00000, default_out, default_dir, wake_en, int_mode, spi_hold};
		for (int i = 0; i < PIN_COUNT; i++) v[29+2*i +: 2] = pin_func[i];
		return v;
	endfunction : seen_set
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	always @(negedge ref_clk) begin
		#2;
		if (pend) check(seen_set(), set_q.size() ? set_q.pop_front() : 47'hX);
		pend = settings_applied;
		if (rsp_valid && rsp_ready) begin
			check({rsp_last, rsp_data}, rsp_q.size() ? rsp_q.pop_front() : 9'hX);
			check(cmd_ready, 1'b0);
		end
	end
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	task automatic run_report(input logic [7:0] code, input logic [2:0] mode);
		logic [63:0][7:0] rep;
		logic [7:0]       c;
		for (int i = 0; i < 64; i++) rep[i] = $random(seed);
		rep[0] = code;
		rep[17][3:1] = mode;
		for (int i = 0; i < PIN_COUNT; i++) rep[4+i] = {6'h00, rep[4+i][1:0]};
		if (code == CMD_SET_VOLATILE) begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				c = rep[4+i];
				if (c == FUNC_CODE_GPIO || c == FUNC_CODE_DED || (c == FUNC_CODE_CS && i < 8))
					e_set[29+2*i +: 2] = c[1:0];
			end
			e_set[28:0] = {rep[13], rep[16], rep[15], rep[17][4], e_set[3:1], rep[17][0]};
			if (mode <= MODE_HIGH_PULSES) e_set[3:1] = mode;
			set_q.push_back(e_set);
			for (int i = 0; i < 64; i++)
				rsp_q.push_back({i == 63, (i == 0) ? CMD_SET_VOLATILE : STATUS_OK});
		end
		svcp_host_model_i.send_report(rep);
	endtask : run_report
	initial begin
		int w;
		pend = 1'b0;
		e_set = rst_set;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		check(seen_set(), rst_set);
		check(cmd_ready, 1'b1);
		$display("test reset values done");
		for (int k = 0; k < 8; k++) begin
			slow = k[0];
			run_report(CMD_SET_VOLATILE, k[2:0]);
		end
		$display("test settings table done");
		run_report(8'h30, 3'h1);
		run_report(CMD_SET_VOLATILE, 3'h2);
		run_report(8'h00, 3'h3);
		$display("test foreign codes done");
		w = 0;
		while ((rsp_q.size() || set_q.size()) && w < 1000) begin
			@(negedge ref_clk);
			w++;
		end
		nrst = 1'b0;
		e_set = rst_set;
		#3;
		check(seen_set(), rst_set);
		@(negedge ref_clk);
		nrst = 1'b1;
		run_report(CMD_SET_VOLATILE, 3'h4);
		w = 0;
		while ((rsp_q.size() || set_q.size()) && w < 1000) begin
			@(negedge ref_clk);
			w++;
		end
		check(rsp_q.size() + set_q.size(), 0);
		$display("test reset in mid run done");
		give_verdict();
	end
	// Allows about four times the expected run.
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
endmodule : tb
`default_nettype wire
